/* File: cps_crosspoint.sv */
// Programming logic of an 8x8 crosspoint: staging and active registers, pin
// strobes sampled on pclk, and an APB window onto the state.
// Assumes pins are asynchronous to pclk and strobes last several pclk periods.
//
// Summary of operation
// - Drive 64 switches; each output picks one of 8 inputs, inputs shareable.
// - Every output has its own enable so it can sit in high-Z.
// - Serial mode: shift output pin shows the staging register MSB.
// - Serial mode: shift input pin feeds the staging shift register.
// - Parallel mode: shift input and output pins are nibble bits 0 and 1.
// - Parallel mode: output select bits pick the output being programmed.
// - Edge strap high: staging copied to active on transfer strobe rise.
// - Edge strap low: active follows staging while transfer strobe is low.
// - Strap and strobe low: changes land at the write strobe edge.
// - Interface strap 1 selects serial, 0 selects parallel programming.
// - Serial write strobe rise shifts the input bit into the staging LSB.
// - Parallel codes 0000-1000 load staging; 1011-1111 run commands.
// - Commands 1011-1100 ignore transfer controls; 1101-1110 touch staging only; 1111 is a soft transfer.
// - Write strobe counts only with low-active select 0, high-active select 1.
`timescale 1ns/10ps
module cps_crosspoint #(
   parameter int NUM_OUT = cps_pkg::NUM_OUT,
   parameter int NUM_IN = cps_pkg::NUM_IN
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cps_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire cps_pkg::cps_pin_in_t pins,
   output logic shift_output_pin_out,
   output logic shift_output_pin_oe_n,
   output cps_pkg::cps_matrix_out_t matrix
);

   typedef struct packed {
      logic [cps_pkg::STAGE_W-1:0] staging;
      logic [cps_pkg::STAGE_W-1:0] active;
      logic wr_prev;
      logic xfer_prev;
      logic pin_lock;
      logic [cps_pkg::COUNT_W-1:0] wr_count;
      logic [cps_pkg::SWITCH_W-1:0] switch_on;
      logic [NUM_OUT-1:0] out_en;
      logic shift_out;
      logic shift_oe_n;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } cps_state_t;

   cps_state_t state_reg;
   cps_state_t state_next;
   cps_pkg::cps_pin_in_t pin_s;
   logic [$bits(cps_pkg::cps_pin_in_t)-1:0] pin_sync_bits;

   // Strobe and data pass the same two stages, so data stays aligned to the edge
   cps_sync #(
      .WIDTH($bits(cps_pkg::cps_pin_in_t))
   ) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pins),
      .sync_out(pin_sync_bits)
   );

   assign pin_s = cps_pkg::cps_pin_in_t'(pin_sync_bits);

   logic serial_mode;
   logic wr_rise;
   logic xfer_rise;
   logic [cps_pkg::CODE_W-1:0] nibble;
   logic [4:0] sel_lsb;
   logic [cps_pkg::CODE_W-1:0] code;
   logic do_xfer;
   logic force_all_off;
   logic force_one_off;
   logic apb_access;
   logic apb_commit;
   logic addr_ok;
   logic [31:0] rd_word;
   logic [31:0] status_word;
   integer o;
   integer i;

   always_comb begin
      state_next = state_reg;
      serial_mode = pin_s.interface_select_strap;
      nibble = {pin_s.parallel_nibble_hi, pin_s.shift_output_pin_in, pin_s.shift_input_pin};
      sel_lsb = {pin_s.output_select_bits, 2'b00};
      code = '0;
      do_xfer = 1'b0;
      force_all_off = 1'b0;
      force_one_off = 1'b0;
      state_next.wr_prev = pin_s.write_strobe;
      state_next.xfer_prev = pin_s.xfer_strobe;

      // Edge taken only while both selects enable the strobe; lock blocks this write strobe, not the transfer strobe
      wr_rise = pin_s.write_strobe && !state_reg.wr_prev && !pin_s.chip_sel_n
         && pin_s.chip_sel && !state_reg.pin_lock;
      xfer_rise = pin_s.xfer_strobe && !state_reg.xfer_prev;

      // APB: first access cycle prepares the answer, second one commits
      apb_access = psel && penable && !state_reg.pready;
      apb_commit = psel && penable && state_reg.pready;
      addr_ok = 1'b1;
      status_word = cps_pkg::ZERO_WORD;
      status_word[cps_pkg::STAT_SERIAL_BIT] = pin_s.interface_select_strap;
      status_word[cps_pkg::STAT_EDGE_BIT] = pin_s.edge_mode_strap;
      status_word[cps_pkg::STAT_XFER_BIT] = pin_s.xfer_strobe;
      status_word[cps_pkg::STAT_OUT_EN_LSB +: NUM_OUT] = state_reg.out_en;
      status_word[cps_pkg::STAT_COUNT_LSB +: cps_pkg::COUNT_W] = state_reg.wr_count;
      rd_word = cps_pkg::ZERO_WORD;
      case (paddr)
         cps_pkg::CTRL_OFS: begin
            rd_word[cps_pkg::CTRL_PIN_LOCK_BIT] = state_reg.pin_lock;
         end
         cps_pkg::STAGING_OFS: begin
            rd_word = state_reg.staging;
         end
         cps_pkg::ACTIVE_OFS: begin
            rd_word = state_reg.active;
         end
         cps_pkg::SWITCH_LO_OFS: begin
            rd_word = state_reg.switch_on[31:0];
         end
         cps_pkg::SWITCH_HI_OFS: begin
            rd_word = state_reg.switch_on[63:32];
         end
         cps_pkg::STATUS_OFS: begin
            rd_word = status_word;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase

      if (apb_access) begin
         state_next.pready = 1'b1;
         state_next.pslverr = !addr_ok;
         state_next.prdata = (pwrite || !addr_ok) ? cps_pkg::ZERO_WORD : rd_word;
      end else begin
         state_next.pready = 1'b0;
         state_next.pslverr = 1'b0;
         state_next.prdata = cps_pkg::ZERO_WORD;
      end

      // Software writes land before pin writes in the same cycle; pins win
      if (apb_commit && pwrite && addr_ok) begin
         case (paddr)
            cps_pkg::CTRL_OFS: begin
               state_next.pin_lock = pwdata[cps_pkg::CTRL_PIN_LOCK_BIT];
               do_xfer = pwdata[cps_pkg::CTRL_SOFT_XFER_BIT];
            end
            cps_pkg::STAGING_OFS: begin
               state_next.staging = pwdata;
            end
            default: begin
               // Read-only words ignore writes without error
            end
         endcase
      end

      if (wr_rise) begin
         state_next.wr_count = state_reg.wr_count + 16'h0001;
         if (serial_mode) begin
            state_next.staging = {state_next.staging[cps_pkg::STAGE_W-2:0], pin_s.shift_input_pin};
         end else begin
            code = nibble;
            if (code <= cps_pkg::CODE_OFF) begin
               state_next.staging[sel_lsb +: cps_pkg::CODE_W] = code;
            end else begin
               // 1001 and 1010 have no meaning and are dropped
               case (code)
                  cps_pkg::CMD_ALL_OFF: begin
                     state_next.staging = cps_pkg::STAGE_RESET;
                     force_all_off = 1'b1;
                  end
                  cps_pkg::CMD_ONE_OFF: begin
                     state_next.staging[sel_lsb +: cps_pkg::CODE_W] = cps_pkg::CODE_OFF;
                     force_one_off = 1'b1;
                  end
                  cps_pkg::CMD_STAGE_CLR: begin
                     state_next.staging = cps_pkg::STAGE_RESET;
                  end
                  cps_pkg::CMD_RESTORE: begin
                     state_next.staging = state_reg.active;
                  end
                  cps_pkg::CMD_SOFT_XFER: begin
                     do_xfer = 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
         end
      end

      // Transfer from staging to active
      if (pin_s.edge_mode_strap) begin
         if (xfer_rise) begin
            state_next.active = state_next.staging;
         end
      end else if (!pin_s.xfer_strobe) begin
         // Transparent: a write edge reaches active in the same pclk as staging
         state_next.active = state_next.staging;
      end
      if (do_xfer) begin
         state_next.active = state_next.staging;
      end
      // Immediate commands override whatever transfer happened this cycle
      if (force_all_off) begin
         state_next.active = cps_pkg::STAGE_RESET;
      end
      if (force_one_off) begin
         state_next.active[sel_lsb +: cps_pkg::CODE_W] = cps_pkg::CODE_OFF;
      end

      // Decode active codes into one-hot switch rows and output enables
      for (o = 0; o < NUM_OUT; o = o + 1) begin
         state_next.out_en[o] = !state_next.active[o*cps_pkg::CODE_W + 3];
         for (i = 0; i < NUM_IN; i = i + 1) begin
            state_next.switch_on[o*NUM_IN + i] = state_next.out_en[o]
               && (state_next.active[o*cps_pkg::CODE_W +: 3] == 3'(i));
         end
      end

      // Shift pin drives only in serial mode; it is an input otherwise
      state_next.shift_out = serial_mode ? state_next.staging[cps_pkg::STAGE_W-1] : 1'b0;
      state_next.shift_oe_n = !serial_mode;
   end

   // Straps are assumed steady; no re-arming on a mid-run change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.staging <= cps_pkg::STAGE_RESET;
         state_reg.active <= cps_pkg::STAGE_RESET;
         state_reg.wr_prev <= 1'b0;
         state_reg.xfer_prev <= 1'b0;
         state_reg.pin_lock <= 1'b0;
         state_reg.wr_count <= '0;
         state_reg.switch_on <= '0;
         state_reg.out_en <= '0;
         state_reg.shift_out <= 1'b0;
         state_reg.shift_oe_n <= 1'b1;
         state_reg.pready <= 1'b0;
         state_reg.pslverr <= 1'b0;
         state_reg.prdata <= cps_pkg::ZERO_WORD;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign shift_output_pin_out = state_reg.shift_out;
   assign shift_output_pin_oe_n = state_reg.shift_oe_n;
   assign matrix.switch_on = state_reg.switch_on;
   assign matrix.video_outputs_en = state_reg.out_en;

endmodule

/* File: cps_crosspoint_sva.sv */
// Checker for the crosspoint programming block: APB answer and pin outcomes.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module cps_crosspoint_sva #(
   parameter int NUM_OUT = cps_pkg::NUM_OUT,
   parameter int NUM_IN = cps_pkg::NUM_IN
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cps_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire cps_pkg::cps_pin_in_t pins,
   input wire logic shift_output_pin_out,
   input wire logic shift_output_pin_oe_n,
   input wire cps_pkg::cps_matrix_out_t matrix
);
   logic rows_ok;
   // One input per output at most, enable only when routed
   always_comb begin
      rows_ok = 1'b1;
      for (int o = 0; o < NUM_OUT; o++)
         if (!$onehot0(matrix.switch_on[o*NUM_IN+:NUM_IN]) ||
             matrix.video_outputs_en[o] != |matrix.switch_on[o*NUM_IN+:NUM_IN])
            rows_ok = 1'b0;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_access;
      $rose(psel && penable);
   endsequence
   // Six quiet cycles outlast the three-edge pin pipeline
   sequence s_quiet;
      (!pins.chip_sel && !psel && !pins.xfer_strobe) [*6];
   endsequence
   a_ready_wait: assert property (s_access |=> pready) else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000) else $error("prdata not idle");
   a_err_unmapped: assert property (s_access ##0 (paddr > cps_pkg::STATUS_OFS) |=> pslverr)
      else $error("unmapped not refused");
   a_oe_serial: assert property (pins.interface_select_strap [*5] |-> !shift_output_pin_oe_n)
      else $error("shift out not driven");
   a_oe_parallel: assert property ((!pins.interface_select_strap) [*5] |-> shift_output_pin_oe_n)
      else $error("shift out driven in parallel");
   a_rows_onehot: assert property (rows_ok) else $error("matrix row bad");
   a_quiet_hold: assert property (s_quiet |=> $stable(matrix)) else $error("matrix moved");
endmodule
bind cps_crosspoint cps_crosspoint_sva #(.NUM_OUT(NUM_OUT), .NUM_IN(NUM_IN)) chk_u (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
   .shift_output_pin_out(shift_output_pin_out), .shift_output_pin_oe_n(shift_output_pin_oe_n),
   .matrix(matrix));

/* File: cps_host.sv */
// Host model driving the programming pins of the crosspoint block.
// Assumes the bench calls its tasks; pins move right after a rising pclk.
`timescale 1ns/10ps
module cps_host (
   input wire logic pclk,
   input wire logic dev_d1,
   input wire logic dev_d1_oe_n,
   output cps_pkg::cps_pin_in_t pins
);
   cps_pkg::cps_pin_in_t p;
   initial begin
      p = '0;
      p.chip_sel = 1'b1;
   end
   // Shared data pin: device level wins while it drives
   always_comb begin
      pins = p;
      pins.shift_output_pin_in = dev_d1_oe_n ? p.shift_output_pin_in : dev_d1;
   end
   // Four cycles each phase, safely above the three-cycle minimum
   task automatic strobe();
      @(posedge pclk) p.write_strobe <= 1'b1;
      repeat (4) @(posedge pclk);
      p.write_strobe <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic par_write(input logic [2:0] sel, input logic [3:0] code);
      @(posedge pclk);
      p.output_select_bits <= sel;
      {p.parallel_nibble_hi, p.shift_output_pin_in, p.shift_input_pin} <= code;
      strobe();
   endtask
   task automatic ser_bit(input logic b);
      @(posedge pclk) p.shift_input_pin <= b;
      strobe();
   endtask
   task automatic xfer();
      @(posedge pclk) p.xfer_strobe <= 1'b1;
      repeat (4) @(posedge pclk);
      p.xfer_strobe <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
endmodule

/* File: cps_pkg.sv */
// Package for the crosspoint programming block: register map, codes, carriers.
// Assumes a 32-bit APB slave and a matrix of 8 outputs by 8 inputs.
package cps_pkg;

   localparam int NUM_OUT = 8;
   localparam int NUM_IN = 8;
   localparam int CODE_W = 4;
   localparam int STAGE_W = NUM_OUT * CODE_W;
   localparam int SWITCH_W = NUM_OUT * NUM_IN;
   localparam int ADDR_W = 8;
   localparam int SYNC_STAGES = 2;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STAGING_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] ACTIVE_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] SWITCH_LO_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] SWITCH_HI_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h14;

   // Control field positions
   localparam int CTRL_SOFT_XFER_BIT = 0;
   localparam int CTRL_PIN_LOCK_BIT = 1;

   // Status field positions
   localparam int STAT_SERIAL_BIT = 0;
   localparam int STAT_EDGE_BIT = 1;
   localparam int STAT_XFER_BIT = 2;
   localparam int STAT_OUT_EN_LSB = 8;
   localparam int STAT_COUNT_LSB = 16;
   localparam int COUNT_W = 16;

   // Nibble codes: 0..7 route an input, 1000 parks the output in high-Z
   localparam logic [CODE_W-1:0] CODE_OFF = 4'h8;
   localparam logic [CODE_W-1:0] CMD_ALL_OFF = 4'hB;
   localparam logic [CODE_W-1:0] CMD_ONE_OFF = 4'hC;
   localparam logic [CODE_W-1:0] CMD_STAGE_CLR = 4'hD;
   localparam logic [CODE_W-1:0] CMD_RESTORE = 4'hE;
   localparam logic [CODE_W-1:0] CMD_SOFT_XFER = 4'hF;

   // Reset values: every output parked
   localparam logic [STAGE_W-1:0] STAGE_RESET = 32'h88888888;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;

   typedef struct packed {
      logic write_strobe;
      logic chip_sel_n;
      logic chip_sel;
      logic xfer_strobe;
      logic edge_mode_strap;
      logic interface_select_strap;
      logic [1:0] parallel_nibble_hi;
      logic shift_output_pin_in;
      logic shift_input_pin;
      logic [2:0] output_select_bits;
   } cps_pin_in_t;

   typedef struct packed {
      logic [SWITCH_W-1:0] switch_on;
      logic [NUM_OUT-1:0] video_outputs_en;
   } cps_matrix_out_t;

endpackage

/* File: cps_sync.sv */
// Two-flop synchroniser for a bundle of pin levels.
// Assumes only level inputs; the first stage feeds the second only.
`timescale 1ns/10ps
module cps_sync #(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

/* File: tb_crosspoint_switch_programming.sv */
// Bench for the crosspoint programming block: APB tasks plus a pin host.
// Assumes the checker is bound in and the host model drives all pins.
`timescale 1ns/10ps
module tb_crosspoint_switch_programming;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, d1_out, d1_oe_n, err;
   logic [cps_pkg::ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd, exp_stage;
   logic [71:0] em;
   cps_pkg::cps_pin_in_t pins;
   cps_pkg::cps_matrix_out_t matrix;
   int miscompares = 0;
   int cmp_count = 0;
   cps_crosspoint dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .shift_output_pin_out(d1_out),
      .shift_output_pin_oe_n(d1_oe_n), .matrix(matrix));
   cps_host host_u (.pclk(pclk), .dev_d1(d1_out), .dev_d1_oe_n(d1_oe_n), .pins(pins));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic check(input string name, input logic [71:0] seen, input logic [71:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Bounded wait: the slave's latency is not assumed
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) check("pready", 0, 1);
   endtask
   // Codes with bit 3 set leave the output in high-Z
   function automatic logic [71:0] exp_mat(input logic [31:0] act);
      logic [71:0] m;
      m = '0;
      for (int o = 0; o < 8; o++)
         if (!act[4*o+3]) begin
            m[8+o*8+act[4*o+:3]] = 1'b1;
            m[o] = 1'b1;
         end
      return m;
   endfunction
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      check("oe_n", d1_oe_n, 1'b1);
      check("matrix", matrix, exp_mat(cps_pkg::STAGE_RESET));
      apb(0, cps_pkg::STAGING_OFS, 0);
      check("staging", rd, cps_pkg::STAGE_RESET);
      $display("test reset done");
      exp_stage = cps_pkg::STAGE_RESET;
      for (int o = 0; o < 8; o++) begin
         host_u.par_write(o[2:0], 4'(7 - o));
         exp_stage[4*o+:4] = 4'(7 - o);
         check("matrix", matrix, exp_mat(exp_stage));
      end
      host_u.par_write(3'h2, 4'h8);
      host_u.par_write(3'h3, 4'h9);
      host_u.par_write(3'h3, 4'hA);
      exp_stage[11:8] = 4'h8;
      check("matrix", matrix, exp_mat(exp_stage));
      host_u.p.chip_sel <= 1'b0;
      host_u.par_write(3'h4, 4'h0);
      host_u.p.chip_sel <= 1'b1;
      host_u.p.chip_sel_n <= 1'b1;
      host_u.par_write(3'h5, 4'h0);
      host_u.p.chip_sel_n <= 1'b0;
      apb(0, cps_pkg::STAGING_OFS, 0);
      check("staging", rd, exp_stage);
      $display("test parallel done");
      host_u.p.edge_mode_strap <= 1'b1;
      repeat (6) @(posedge pclk);
      host_u.par_write(3'h0, 4'h5);
      apb(0, cps_pkg::ACTIVE_OFS, 0);
      check("active", rd, exp_stage);
      exp_stage[3:0] = 4'h5;
      host_u.xfer();
      apb(0, cps_pkg::ACTIVE_OFS, 0);
      check("active", rd, exp_stage);
      host_u.par_write(3'h1, 4'h6);
      host_u.par_write(3'h7, 4'hF);
      exp_stage[7:4] = 4'h6;
      check("matrix", matrix, exp_mat(exp_stage));
      host_u.par_write(3'h0, 4'hB);
      check("enables", matrix.video_outputs_en, 8'h00);
      $display("test edge done");
      host_u.p.interface_select_strap <= 1'b1;
      host_u.p.edge_mode_strap <= 1'b0;
      repeat (6) @(posedge pclk);
      check("oe_n", d1_oe_n, 1'b0);
      exp_stage = 32'hA5C30718;
      for (int i = 31; i >= 0; i--) host_u.ser_bit(exp_stage[i]);
      apb(0, cps_pkg::STAGING_OFS, 0);
      check("staging", rd, exp_stage);
      check("shift_out", d1_out, exp_stage[31]);
      check("matrix", matrix, exp_mat(exp_stage));
      $display("test serial done");
      apb(1, cps_pkg::ACTIVE_OFS, 32'h00000000);
      apb(0, cps_pkg::ACTIVE_OFS, 0);
      check("active", rd, exp_stage);
      apb(0, 8'h40, 0);
      check("pslverr", err, 1'b1);
      check("prdata", rd, 0);
      $display("test bus done");
      apb(1, cps_pkg::STAGING_OFS, 32'h01234567);
      apb(0, cps_pkg::ACTIVE_OFS, 0);
      check("active", rd, 32'h01234567);
      em = exp_mat(32'h01234567);
      apb(0, cps_pkg::SWITCH_LO_OFS, 0);
      check("switch_lo", rd, em[39:8]);
      apb(0, cps_pkg::SWITCH_HI_OFS, 0);
      check("switch_hi", rd, em[71:40]);
      // Locked pins: the strobe must neither shift nor count
      apb(1, cps_pkg::CTRL_OFS, 32'h00000002);
      host_u.ser_bit(1'b0);
      apb(0, cps_pkg::STAGING_OFS, 0);
      check("staging", rd, 32'h01234567);
      apb(0, cps_pkg::STATUS_OFS, 0);
      check("status", rd, {16'h002F, em[7:0], 8'h01});
      apb(1, cps_pkg::CTRL_OFS, 32'h00000000);
      $display("test registers done");
      host_u.p.edge_mode_strap <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(1, cps_pkg::STAGING_OFS, 32'h76543210);
      apb(0, cps_pkg::ACTIVE_OFS, 0);
      check("active", rd, 32'h01234567);
      apb(1, cps_pkg::CTRL_OFS, 32'h00000001);
      apb(0, cps_pkg::ACTIVE_OFS, 0);
      check("active", rd, 32'h76543210);
      apb(0, cps_pkg::CTRL_OFS, 0);
      check("ctrl", rd, 32'h00000000);
      host_u.p.interface_select_strap <= 1'b0;
      repeat (6) @(posedge pclk);
      host_u.par_write(3'h3, 4'hC);
      check("matrix", matrix, exp_mat(32'h76548210));
      host_u.par_write(3'h0, 4'hD);
      apb(0, cps_pkg::STAGING_OFS, 0);
      check("staging", rd, cps_pkg::STAGE_RESET);
      check("matrix", matrix, exp_mat(32'h76548210));
      host_u.par_write(3'h0, 4'hE);
      apb(0, cps_pkg::STAGING_OFS, 0);
      check("staging", rd, 32'h76548210);
      $display("test commands done");
      summarize();
   end
   // Tests need under 1000 cycles; this is five times that
   initial begin
      #200000;
      miscompares++;
      summarize();
   end
endmodule
